// ---- rtl/fses_consts.svh ----
// constants of the flash sequencer error/monitor status block
// assumes inclusion by bare name from rtl files
`ifndef FSES_CONSTS_SVH
`define FSES_CONSTS_SVH

// register byte offsets on the apb slave
`define FSES_OFS_STATUS      12'h000
`define FSES_OFS_ECC_TMODE   12'h004
`define FSES_OFS_DUMMY_ECC   12'h008
`define FSES_OFS_IRQ_STATUS  12'h00C
`define FSES_OFS_IRQ_MASK    12'h010

// flash_status_word bit positions
`define FSES_BIT_ENTRY_ERR   22
`define FSES_BIT_SEC_ERR     21
`define FSES_BIT_MISC_ERR    20
`define FSES_BIT_RSVD        19
`define FSES_BIT_EBUF_FULL   18
`define FSES_BIT_BP_DOUBLE   17
`define FSES_BIT_BP_SINGLE   16

// ecc_test_mode_register field
`define FSES_BIT_ECC_DIS     0

// interrupt status / mask bits
`define FSES_IRQ_LOCK        0
`define FSES_IRQ_CORR        1
`define FSES_IRQ_FULL        2
`define FSES_IRQ_N           3

// reset values
`define FSES_RST_ECC_DIS     1'h0
`define FSES_RST_IRQ         3'h0
`define FSES_RST_MASK        3'h0
`define FSES_RST_DATA        32'h0000_0000

// buffer geometry defaults
`define FSES_DMY_W           8
`define FSES_EBUF_DEPTH      4

`endif

// ---- rtl/fses_pkg.sv ----
// types of the flash sequencer error/monitor status block
// assumes nothing beyond the constants header
package fses_pkg;

    // command currently processed by the sequencer
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_CF_PROGRAM,
        CMD_CF_BLOCK_ERASE,
        CMD_BP_SETTINGS,
        CMD_OTHER
    } fses_cmd_t;

    // register selected by an apb address
    typedef enum logic [2:0] {
        SEL_STATUS,
        SEL_ECC_TMODE,
        SEL_DUMMY_ECC,
        SEL_IRQ_STATUS,
        SEL_IRQ_MASK,
        SEL_NONE
    } fses_sel_t;

    // state of the top level
    typedef struct packed {
        logic        ecc_dis;
        logic [2:0]  irq_sts;
        logic [2:0]  irq_mask;
        logic [31:0] prdata;
        logic        lock_prev;
        logic        corr_prev;
        logic        full_prev;
    } fses_top_st_t;

endpackage

// ---- rtl/fses_flag_bank.sv ----
// sticky flag bank, set wins over a simultaneous clear
// assumes set and clear come from logic on pclk
`timescale 1ns/1ps
module fses_flag_bank #(
    parameter int N = 5
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // control
    input  wire logic [N-1:0] set,
    input  wire logic         clr,
    // flags
    output logic      [N-1:0] flags
);
    typedef struct packed {
        logic [N-1:0] flags;
    } fses_flag_st_t;

    fses_flag_st_t st_q;
    fses_flag_st_t st_d;

    if (N < 1) begin
        $error("fses_flag_bank: N must be at least 1");
    end

    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.flags = (st_q.flags & ~{N{clr}}) | set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags = st_q.flags;
endmodule

// ---- rtl/fses_ecc_buf.sv ----
// dummy ecc entry buffer in flip-flops, valid/ready on both sides
// assumes both sides on pclk; full follows the entry count directly
`timescale 1ns/1ps
module fses_ecc_buf #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    // fill side
    input  wire logic         push_valid,
    output logic              push_ready,
    input  wire logic [W-1:0] push_data,
    // drain side
    output logic              pop_valid,
    input  wire logic         pop_ready,
    output logic      [W-1:0] pop_data,
    // status
    output logic              full
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [AW:0]             cnt;
    } fses_buf_st_t;

    fses_buf_st_t st_q;
    fses_buf_st_t st_d;
    logic         do_push;
    logic         do_pop;

    if (DEPTH < 2 || W < 1) begin
        $error("fses_ecc_buf: DEPTH must be >= 2 and W >= 1");
    end

    function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
        nxt = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
    endfunction

    assign full       = (st_q.cnt == (AW+1)'(DEPTH));
    assign push_ready = ce && !full;
    assign pop_valid  = ce && (st_q.cnt != '0);
    assign pop_data   = st_q.mem[st_q.rd];
    assign do_push    = push_valid && push_ready;
    assign do_pop     = pop_valid && pop_ready;

    always_comb begin
        st_d = st_q;
        if (do_push) begin
            st_d.mem[st_q.wr] = push_data;
            st_d.wr = nxt(st_q.wr);
        end
        if (do_pop) begin
            st_d.rd = nxt(st_q.rd);
        end
        if (do_push && !do_pop) begin
            st_d.cnt = st_q.cnt + (AW+1)'(1);
        end else if (do_pop && !do_push) begin
            st_d.cnt = st_q.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ---- rtl/fses_top.sv ----
// error and monitor bits 22..16 of the flash status word, with apb slave,
// dummy ecc buffer and interrupt logic
// assumes sequencer-side event, command and drain signals are on pclk
//
// How it works
// R1 - error flags 22..20 set, force command lock
// R2 - clear-status or forced-stop start clears flags
// R3 - reserved bit 19 always reads zero
// R4 - internal ecc buffer, full shown on bit 18
// R5 - dummy register feeds buffer only when disabled
// R6 - dummy write while full stalls apb
// R7 - full flag rises when buffer fills programming
// R8 - full flag drops once buffer not full
// R9 - protect-area double error sets 17, locks
// R10 - protect area read by three command kinds
// R11 - protect-area corrected error sets 16, no lock
// R12 - master tolerates stalls, clears lock afterwards
`timescale 1ns/1ps
`include "fses_consts.svh"
module fses_top #(
    parameter int AW     = 12,
    parameter int DMY_W  = `FSES_DMY_W,
    parameter int EDEPTH = `FSES_EBUF_DEPTH
) (
    // clock, reset, enable
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              ce,

    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [AW-1:0]     paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,

    // error detection from the sequencer
    input  wire logic              entry_err_det,
    input  wire logic              security_err_det,
    input  wire logic              misc_err_det,

    // protect area ecc monitor from the sequencer
    input  wire logic              bp_read_active,
    input  wire fses_pkg::fses_cmd_t cmd_kind,
    input  wire logic              bp_double_det,
    input  wire logic              bp_single_det,

    // command starts
    input  wire logic              status_clear_start,
    input  wire logic              forced_stop_start,
    input  wire logic              prog_cmd_active,

    // ecc buffer drain
    output logic                   ecc_pop_valid,
    input  wire logic              ecc_pop_ready,
    output logic      [DMY_W-1:0]  ecc_pop_data,

    // status out
    output logic                   command_lock,
    output logic                   ecc_buffer_full_flag,
    output logic                   irq
);
    // five flags in the bank, three interrupt sources
    localparam int NF = 5;
    localparam int NIRQ = `FSES_IRQ_N;

    // flag positions inside the bank
    localparam int F_ENTRY  = 4;
    localparam int F_SEC    = 3;
    localparam int F_MISC   = 2;
    localparam int F_DOUBLE = 1;
    localparam int F_SINGLE = 0;

    if (AW < 5) begin
        $error("fses_top: AW must be at least 5");
    end
    if (DMY_W < 1 || DMY_W > 32) begin
        $error("fses_top: DMY_W must be in 1..32");
    end
    if (EDEPTH < 2) begin
        $error("fses_top: EDEPTH must be at least 2");
    end
    if (NIRQ != 3) begin
        $error("fses_top: exactly three interrupt sources");
    end

    // state register and its next value
    fses_pkg::fses_top_st_t st_q;
    fses_pkg::fses_top_st_t st_d;

    // flag bank side
    logic [NF-1:0]    flag_set;
    logic [NF-1:0]    flags;
    logic             flag_clr;
    logic             bp_check;

    // buffer side
    logic             push_valid;
    logic             push_ready;
    logic             ebuf_full;

    // apb side
    logic             setup;
    logic             access;
    logic             wr_done;
    logic             dmy_wr;
    logic             dmy_fill;

    // interrupt side
    logic             lock_rise;
    logic             corr_rise;
    logic             full_rise;
    logic [2:0]       irq_evt;

    // register selected by paddr
    fses_pkg::fses_sel_t sel;

    // address to register select
    function automatic fses_pkg::fses_sel_t decode(input logic [AW-1:0] a);
        logic [11:0] a12;
        a12 = 12'(a);
        // word aligned and inside the 12-bit map only
        if (a[1:0] != 2'h0 || a != AW'(a12)) begin
            decode = fses_pkg::SEL_NONE;
        end else begin
            case (a12)
                `FSES_OFS_STATUS:     decode = fses_pkg::SEL_STATUS;
                `FSES_OFS_ECC_TMODE:  decode = fses_pkg::SEL_ECC_TMODE;
                `FSES_OFS_DUMMY_ECC:  decode = fses_pkg::SEL_DUMMY_ECC;
                `FSES_OFS_IRQ_STATUS: decode = fses_pkg::SEL_IRQ_STATUS;
                `FSES_OFS_IRQ_MASK:   decode = fses_pkg::SEL_IRQ_MASK;
                default:              decode = fses_pkg::SEL_NONE;
            endcase
        end
    endfunction

    // protect area read happens only for these command kinds
    function automatic logic reads_bp(input fses_pkg::fses_cmd_t k);
        case (k)
            fses_pkg::CMD_CF_PROGRAM:     reads_bp = 1'b1; // [R10]
            fses_pkg::CMD_CF_BLOCK_ERASE: reads_bp = 1'b1; // [R10]
            fses_pkg::CMD_BP_SETTINGS:    reads_bp = 1'b1; // [R10]
            default:                      reads_bp = 1'b0;
        endcase
    endfunction

    // assemble the status word from live flags
    function automatic logic [31:0] status_word(input logic [NF-1:0] f,
                                                input logic full_f);
        logic [31:0] w;
        w = `FSES_RST_DATA;
        w[`FSES_BIT_ENTRY_ERR] = f[F_ENTRY];
        w[`FSES_BIT_SEC_ERR]   = f[F_SEC];
        w[`FSES_BIT_MISC_ERR]  = f[F_MISC];
        w[`FSES_BIT_RSVD]      = 1'b0;        // [R3]
        // bit 18 follows the live entry count
        w[`FSES_BIT_EBUF_FULL] = full_f;      // [R4]
        w[`FSES_BIT_BP_DOUBLE] = f[F_DOUBLE];
        w[`FSES_BIT_BP_SINGLE] = f[F_SINGLE];
        status_word = w;
    endfunction

    // apb phase decode
    assign sel    = decode(paddr);
    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign dmy_wr = access && pwrite && (sel == fses_pkg::SEL_DUMMY_ECC);

    // dummy register is the buffer's input only with ecc disabled
    assign dmy_fill   = dmy_wr && st_q.ecc_dis && prog_cmd_active; // [R5]
    assign push_valid = dmy_fill && ce;

    // stall the dummy write until the buffer has room
    // room shows one cycle after a pop, not in the pop cycle
    assign pready  = ce && !(dmy_fill && !push_ready); // [R6] [R12]
    // unmapped or unaligned: error with no wait state
    assign pslverr = access && (sel == fses_pkg::SEL_NONE);
    assign wr_done = access && pwrite && pready;
    // stands from a read setup to the next one
    assign prdata  = st_q.prdata;

    // error and monitor flag sources
    assign bp_check = bp_read_active && reads_bp(cmd_kind); // [R10]
    assign flag_set[F_ENTRY]  = entry_err_det;              // [R1]
    assign flag_set[F_SEC]    = security_err_det;           // [R1]
    assign flag_set[F_MISC]   = misc_err_det;               // [R1]
    // ecc monitor events count only while the area is read
    assign flag_set[F_DOUBLE] = bp_check && bp_double_det;  // [R9]
    assign flag_set[F_SINGLE] = bp_check && bp_single_det;  // [R11]
    // a set in the clearing cycle wins inside the bank
    assign flag_clr = status_clear_start || forced_stop_start; // [R2]

    // five sticky flags, bits 22..20, 17 and 16
    fses_flag_bank #(
        .N       (NF)
    ) u_flags (
        .pclk    (pclk),
        .presetn (presetn),
        .ce      (ce),
        .set     (flag_set),
        .clr     (flag_clr),
        .flags   (flags)
    );

    // lock while any error or double-error flag stands; single does not
    assign command_lock = flags[F_ENTRY] || flags[F_SEC]
                       || flags[F_MISC]  || flags[F_DOUBLE]; // [R1] [R9] [R11]

    // dummy ecc entries wait here for the sequencer
    fses_ecc_buf #(
        .W          (DMY_W),
        .DEPTH      (EDEPTH)
    ) u_ebuf (
        .pclk       (pclk),
        .presetn    (presetn),
        .ce         (ce),
        .push_valid (push_valid),
        .push_ready (push_ready),
        .push_data  (pwdata[DMY_W-1:0]),
        .pop_valid  (ecc_pop_valid),
        .pop_ready  (ecc_pop_ready),
        .pop_data   (ecc_pop_data),
        .full       (ebuf_full)
    );

    // full rises only by pushes, falls at the first pop
    assign ecc_buffer_full_flag = ebuf_full; // [R4] [R7] [R8]

    // interrupt events on rising edges of the monitored conditions
    assign lock_rise = command_lock && !st_q.lock_prev;
    assign corr_rise = flags[F_SINGLE] && !st_q.corr_prev;
    assign full_rise = ebuf_full && !st_q.full_prev;

    always_comb begin
        irq_evt = 3'h0;
        irq_evt[`FSES_IRQ_LOCK] = lock_rise;
        irq_evt[`FSES_IRQ_CORR] = corr_rise;
        irq_evt[`FSES_IRQ_FULL] = full_rise;
    end

    // the mask gates only the output, never the recording
    assign irq = |(st_q.irq_sts & st_q.irq_mask);

    always_comb begin
        // ce low leaves every field as it was
        st_d = st_q;
        if (ce) begin
            // levels of the cycle before, for the edge detectors
            st_d.lock_prev = command_lock;
            st_d.corr_prev = flags[F_SINGLE];
            st_d.full_prev = ebuf_full;

            // read data captured in the setup cycle
            if (setup && !pwrite) begin
                case (sel)
                    fses_pkg::SEL_STATUS:
                        st_d.prdata = status_word(flags, ebuf_full);
                    fses_pkg::SEL_ECC_TMODE:
                        st_d.prdata = {31'h0, st_q.ecc_dis};
                    fses_pkg::SEL_IRQ_STATUS:
                        st_d.prdata = {29'h0, st_q.irq_sts};
                    fses_pkg::SEL_IRQ_MASK:
                        st_d.prdata = {29'h0, st_q.irq_mask};
                    default:
                        st_d.prdata = `FSES_RST_DATA;
                endcase
            end

            // writes take effect at the completing edge
            if (wr_done && pstrb[0]) begin
                case (sel)
                    fses_pkg::SEL_ECC_TMODE:
                        st_d.ecc_dis = pwdata[`FSES_BIT_ECC_DIS];
                    fses_pkg::SEL_IRQ_STATUS:
                        st_d.irq_sts = st_q.irq_sts & ~pwdata[2:0];
                    fses_pkg::SEL_IRQ_MASK:
                        st_d.irq_mask = pwdata[2:0];
                    // the status word is read-only; writes vanish
                    default: ;
                endcase
            end

            // event set wins over a write-one clear
            st_d.irq_sts = st_d.irq_sts | irq_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q.ecc_dis   <= `FSES_RST_ECC_DIS;
            st_q.irq_sts   <= `FSES_RST_IRQ;
            st_q.irq_mask  <= `FSES_RST_MASK;
            st_q.prdata    <= `FSES_RST_DATA;
            st_q.lock_prev <= 1'b0;
            st_q.corr_prev <= 1'b0;
            st_q.full_prev <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

// ---- sim/fses_top_checker.sv ----
// assertions on the ports of the flash status error/monitor block
// assumes pstrb lane 0 set on every write
`timescale 1ns/1ps
`include "fses_consts.svh"
module fses_top_checker #(
    parameter int AW = 12
) (
    // clock and reset
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          ce,
    // apb
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          pready,
    input wire logic [31:0]   prdata,
    // sequencer side and status
    input wire logic          entry_err_det,
    input wire logic          security_err_det,
    input wire logic          misc_err_det,
    input wire logic          bp_read_active,
    input wire fses_pkg::fses_cmd_t cmd_kind,
    input wire logic          bp_double_det,
    input wire logic          bp_single_det,
    input wire logic          status_clear_start,
    input wire logic          forced_stop_start,
    input wire logic          prog_cmd_active,
    input wire logic          ecc_pop_valid,
    input wire logic          ecc_pop_ready,
    input wire logic          command_lock,
    input wire logic          ecc_buffer_full_flag
);
    logic dis_q, err_any, bp_ok, dmy_acc, dmy_wr, st_rd;
    assign err_any = entry_err_det | security_err_det | misc_err_det;
    assign bp_ok = bp_read_active && (cmd_kind inside {
        fses_pkg::CMD_CF_PROGRAM, fses_pkg::CMD_CF_BLOCK_ERASE,
        fses_pkg::CMD_BP_SETTINGS});
    assign dmy_acc = psel && penable && pwrite
        && paddr == `FSES_OFS_DUMMY_ECC;
    assign dmy_wr = dmy_acc && pready && dis_q && prog_cmd_active;
    assign st_rd = psel && penable && pready && !pwrite
        && paddr == `FSES_OFS_STATUS;
    // mirror of the ecc disable control bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis_q <= 1'h0;
        end else if (psel && penable && pready && pwrite
                     && paddr == `FSES_OFS_ECC_TMODE) begin
            dis_q <= pwdata[`FSES_BIT_ECC_DIS];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_clr;
        (status_clear_start || forced_stop_start) && !err_any
        && !bp_double_det && !bp_single_det && ce;
    endsequence
    sequence s_stall;
        dmy_acc && dis_q && prog_cmd_active && ecc_buffer_full_flag
        && !ecc_pop_ready;
    endsequence
    property p_err_lock; err_any && ce |=> command_lock; endproperty
    a_err_lock: assert property (p_err_lock)
        else $error("error pulse did not lock");
    property p_clear; s_clr |=> !command_lock; endproperty
    a_clear: assert property (p_clear)
        else $error("lock survived a clear");
    property p_rsvd; st_rd |-> !prdata[`FSES_BIT_RSVD]; endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("reserved status bit read as one");
    property p_stall; s_stall |-> !pready; endproperty
    a_stall: assert property (p_stall)
        else $error("write to full buffer not stalled");
    property p_full_rise; $rose(ecc_buffer_full_flag) |-> $past(dmy_wr);
    endproperty
    a_full_rise: assert property (p_full_rise)
        else $error("full flag rose without a buffered write");
    property p_full_drop;
        ecc_buffer_full_flag && ecc_pop_valid && ecc_pop_ready
        |=> !ecc_buffer_full_flag;
    endproperty
    a_full_drop: assert property (p_full_drop)
        else $error("full flag stayed after a drain");
    property p_bp_dbl;
        bp_double_det && bp_ok && ce |=> command_lock;
    endproperty
    a_bp_dbl: assert property (p_bp_dbl)
        else $error("double error did not lock");
    property p_single;
        bp_single_det && !bp_double_det && !err_any && !command_lock
        |=> !command_lock;
    endproperty
    a_single: assert property (p_single)
        else $error("corrected error caused a lock");
endmodule

bind fses_top fses_top_checker #(.AW(AW)) u_checker (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .entry_err_det(entry_err_det),
    .security_err_det(security_err_det), .misc_err_det(misc_err_det),
    .bp_read_active(bp_read_active), .cmd_kind(cmd_kind),
    .bp_double_det(bp_double_det), .bp_single_det(bp_single_det),
    .status_clear_start(status_clear_start),
    .forced_stop_start(forced_stop_start),
    .prog_cmd_active(prog_cmd_active), .ecc_pop_valid(ecc_pop_valid),
    .ecc_pop_ready(ecc_pop_ready), .command_lock(command_lock),
    .ecc_buffer_full_flag(ecc_buffer_full_flag));

// ---- sim/fses_cpu_model.sv ----
// apb master standing in for the cpu that issues flash commands
// assumes callers enter xfer just after a rising pclk edge
`timescale 1ns/1ps
module fses_cpu_model (
    // clock
    input wire logic    pclk,
    // apb master
    output logic        psel = 1'h0,
    output logic        penable = 1'h0,
    output logic        pwrite = 1'h0,
    output logic [11:0] paddr = 12'h000,
    output logic [31:0] pwdata = 32'h0,
    input wire logic    pready,
    // hang seen
    output logic        tmo = 1'h0
);
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        // sits out stalled writes, but not forever
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 400);
        if (pready !== 1'h1) tmo <= 1'h1;
        psel <= 1'h0;
        penable <= 1'h0;
        // released lines must not keep the last value
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule

// ---- sim/fses_top_tb_top.sv ----
// bench of the flash status error/monitor block, notes then compares
// assumes the cpu model drives apb; events and drain are driven here
`timescale 1ns/1ps
`include "fses_consts.svh"
module fses_top_tb_top;
    logic        pclk = 1'h0;
    logic        presetn = 1'h0;
    logic        ce = 1'h1;
    logic        psel, penable, pwrite, pready, pslverr, tmo, irq;
    logic        command_lock, ecc_buffer_full_flag, ecc_pop_valid;
    logic        bp_read_active = 1'h1;
    logic        prog_cmd_active = 1'h0;
    logic        ecc_pop_ready = 1'h0;
    logic [6:0]  ev = 7'h00;
    logic [7:0]  ecc_pop_data;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [32:0] rq[$];
    logic [7:0]  dq[$];
    int          fails = 0;
    int          comparisons = 0;
    int          cyc = 0;
    fses_pkg::fses_cmd_t cmd_kind = fses_pkg::CMD_NONE;
    always #2 pclk = ~pclk;
    fses_cpu_model cpu (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .tmo(tmo));
    fses_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .entry_err_det(ev[0]),
        .security_err_det(ev[1]), .misc_err_det(ev[2]),
        .bp_read_active(bp_read_active), .cmd_kind(cmd_kind),
        .bp_double_det(ev[3]), .bp_single_det(ev[4]),
        .status_clear_start(ev[5]), .forced_stop_start(ev[6]),
        .prog_cmd_active(prog_cmd_active), .ecc_pop_valid(ecc_pop_valid),
        .ecc_pop_ready(ecc_pop_ready), .ecc_pop_data(ecc_pop_data),
        .command_lock(command_lock), .irq(irq),
        .ecc_buffer_full_flag(ecc_buffer_full_flag));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        rq.push_back(e);
        cpu.xfer(1'h0, a, 32'h0);
    endtask
    task automatic pulse(input int i);
        ev <= 7'h01 << i;
        @(posedge pclk);
        ev <= 7'h00;
        @(posedge pclk);
    endtask
    // oldest note against each finished read and each drained entry
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, rq.size() ? rq.pop_front() : 33'hX);
        if (ecc_pop_valid && ecc_pop_ready)
            check(ecc_pop_data, dq.size() ? dq.pop_front() : 8'hX);
        if (tmo || cyc > 20000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        int k;
        logic e;
        void'($urandom(32'hE703));
        repeat (8) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rd(`FSES_OFS_STATUS, 33'h0);
        rd(`FSES_OFS_ECC_TMODE, 33'h0);
        rd(12'h020, 33'h1_0000_0000);
        for (k = 0; k < 3; k++) begin
            pulse(k);
            check(command_lock, 1'h1);
            cpu.xfer(1'h1, `FSES_OFS_STATUS, 32'hFFFF_FFFF);
            rd(`FSES_OFS_STATUS, 33'h40_0000 >> k);
            pulse(5 + k % 2);
            rd(`FSES_OFS_STATUS, 33'h0);
        end
        ce <= 1'h0;
        pulse(1);
        check({command_lock, pready}, 2'h0);
        ce <= 1'h1;
        cpu.xfer(1'h1, `FSES_OFS_IRQ_STATUS, 32'h7);
        cpu.xfer(1'h1, `FSES_OFS_IRQ_MASK, 32'h6);
        rd(`FSES_OFS_IRQ_MASK, 33'h6);
        pulse(2);
        repeat (2) @(posedge pclk);
        check(irq, 1'h0);
        rd(`FSES_OFS_IRQ_STATUS, 33'h1);
        cpu.xfer(1'h1, `FSES_OFS_IRQ_MASK, 32'h7);
        check(irq, 1'h1);
        pulse(6);
        cpu.xfer(1'h1, `FSES_OFS_IRQ_STATUS, 32'h1);
        check(irq, 1'h0);
        for (k = 0; k < 6; k++) begin
            cmd_kind <= fses_pkg::fses_cmd_t'(k == 5 ? 1 : k);
            bp_read_active <= (k != 5);
            e = (k >= 1 && k <= 3);
            pulse(4);
            check(command_lock, 1'h0);
            pulse(3);
            check(command_lock, e);
            rd(`FSES_OFS_STATUS, {e, e, 16'h0});
            pulse(5 + k % 2);
        end
        cpu.xfer(1'h1, `FSES_OFS_ECC_TMODE, 32'h1);
        prog_cmd_active <= 1'h1;
        for (k = 0; k <= `FSES_EBUF_DEPTH; k++) begin
            d = $urandom;
            dq.push_back(d[7:0]);
            if (k < `FSES_EBUF_DEPTH) cpu.xfer(1'h1, `FSES_OFS_DUMMY_ECC, d);
        end
        check(ecc_buffer_full_flag, 1'h1);
        rd(`FSES_OFS_STATUS, 33'h4_0000);
        fork
            cpu.xfer(1'h1, `FSES_OFS_DUMMY_ECC, d);
            begin
                repeat (4) @(posedge pclk);
                check(pready, 1'h0);
                ecc_pop_ready <= 1'h1;
            end
        join
        for (k = 0; k < 50 && ecc_pop_valid; k++) @(posedge pclk);
        if (k == 50) begin
            fails++;
            test_done();
        end
        ecc_pop_ready <= 1'h0;
        check(ecc_buffer_full_flag, 1'h0);
        check(dq.size(), 0);
        cpu.xfer(1'h1, `FSES_OFS_ECC_TMODE, 32'h0);
        cpu.xfer(1'h1, `FSES_OFS_DUMMY_ECC, $urandom);
        check(ecc_pop_valid, 1'h0);
        test_done();
    end
endmodule
